// ==== bench/qrs_host_model.sv ====
// Purpose: Host side of the pins: mode, force, status select, count pulse
// Assumes: Pull resistors resolved here; floating wires show inverted last value
// Notes: Pins change by non-blocking assignment at the rising edge
`timescale 1ns/100ps
`default_nettype none
module qrs_host_model
    import qrs_pkg::*;
(
    // Clock
    input  wire logic       clk,
    // Device pins
    input  wire logic [3:0] chan_irq_out,
    input  wire logic [3:0] chan_irq_oe,
    input  wire logic [7:0] data_out,
    input  wire logic       data_oe,
    // Host pins
    output logic            bus_mode_strobe,
    output logic            irq_force_enable,
    output logic            status_snapshot_sel_n,
    output logic            terminal_count_pulse,
    // Resolved wires
    output logic [3:0]      irq_wire,
    output logic [7:0]      data_bus
);
    logic [3:0] last_irq;
    logic [7:0] last_bus;
    initial
    begin
        bus_mode_strobe       = 1'b1;
        irq_force_enable      = QRS_PULLDOWN_LVL;
        status_snapshot_sel_n = QRS_PULLUP_LVL;
        terminal_count_pulse  = 1'b0;
        last_irq              = 4'h0;
        last_bus              = 8'h00;
    end
    always @(posedge clk)
    begin
        last_irq <= irq_wire;
        last_bus <= data_bus;
    end
    // Open-drain request pin has its pull-up in read/write-select mode
    always_comb
    begin
        data_bus = data_oe ? data_out : ~last_bus;
        irq_wire = (chan_irq_oe & chan_irq_out) | (~chan_irq_oe & ~last_irq);
        if (!bus_mode_strobe && !chan_irq_oe[0])
        begin
            irq_wire[0] = QRS_PULLUP_LVL;
        end
    end
    // Force pin is held low in read/write-select mode
    task automatic set_mode(input logic m, input logic f);
        @(posedge clk);
        bus_mode_strobe  <= m;
        irq_force_enable <= m & f;
    endtask
    task automatic pulse_tc();
        @(posedge clk);
        terminal_count_pulse <= 1'b1;
        @(posedge clk);
        terminal_count_pulse <= 1'b0;
    endtask
    task automatic read_status(output logic [7:0] v, output logic ok);
        int n;
        ok = 1'b0;
        v  = 8'h00;
        @(posedge clk);
        status_snapshot_sel_n <= 1'b0;
        for (n = 0; n < 8 && !ok; n++)
        begin
            @(posedge clk);
            ok = (data_oe === 1'b1);
            v  = data_bus;
        end
        status_snapshot_sel_n <= 1'b1;
    endtask
endmodule
`default_nettype wire

// ==== bench/qrs_irq_ready_test.sv ====
// Purpose: Pin-level tests of interrupt, ready, request and status paths
// Assumes: Expected values worked out from the input pattern only
// Notes: Outputs sampled at the falling edge
`timescale 1ns/100ps
`default_nettype none
module qrs_irq_ready_test
    import qrs_pkg::*;
;
    logic clk = 1'b0, arst_n = 1'b0, csd_n = 1'b1, tc, mode, force_en, sel_n, d_oe, ok, d_en;
    logic [3:0] pend = 4'h0, en = 4'h0, txe = 4'h0, rxe = 4'h0;
    logic [3:0] room = 4'h0, above = 4'h0, rxd = 4'h0;
    logic [3:0] io, ie, tx_n, rx_n, txr, rxr, irq_w;
    logic ctx_n, crx_n;
    logic [7:0] dout, dbus, v;
    int bad_count = 0, samples_checked = 0, i;
    initial
    begin
        forever #12.5 clk = ~clk;
    end
    qrs_irq_ready u_qrs_irq_ready (.clk(clk), .arst_n(arst_n), .bus_mode_strobe(mode),
        .chan_d_select_n(csd_n), .irq_force_enable(force_en), .status_snapshot_sel_n(sel_n),
        .terminal_count_pulse(tc), .chan_irq_pending(pend), .irq_output_enable_bit(en),
        .tx_xfer_enable(txe), .rx_xfer_enable(rxe), .tx_has_room(room),
        .tx_above_trigger(above), .rx_has_data(rxd), .chan_d_enable(d_en),
        .chan_irq_out(io), .chan_irq_oe(ie), .chan_tx_room_n(tx_n), .chan_rx_avail_n(rx_n),
        .combined_tx_room_n(ctx_n), .combined_rx_avail_n(crx_n), .tx_xfer_request(txr),
        .rx_xfer_request(rxr), .data_out(dout), .data_oe(d_oe));
    qrs_host_model u_qrs_host_model (.clk(clk), .chan_irq_out(io), .chan_irq_oe(ie),
        .data_out(dout), .data_oe(d_oe), .bus_mode_strobe(mode), .irq_force_enable(force_en),
        .status_snapshot_sel_n(sel_n), .terminal_count_pulse(tc), .irq_wire(irq_w),
        .data_bus(dbus));
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic gap(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask
    task automatic wrap_up();
        $display("checked %0d, mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial
    begin
        repeat (6) @(posedge clk);
        arst_n <= 1'b1;
        gap(4);
        check({tx_n, rx_n}, 8'hff);
        check({txr, rxr}, 8'h00);
        // Strobe mode: enable bits, then force
        for (i = 0; i < 4; i++)
        begin
            @(posedge clk);
            en   <= 4'h1 << i;
            pend <= 4'ha;
            gap(2);
            check(ie, 4'h1 << i);
            check(io & ie, 4'ha & (4'h1 << i));
        end
        u_qrs_host_model.set_mode(1'b1, 1'b1);
        gap(4);
        check(ie, 4'hf);
        check(irq_w, 4'ha);
        u_qrs_host_model.set_mode(1'b1, 1'b0);
        gap(4);
        check(ie, 4'h8);
        @(posedge clk);
        csd_n <= 1'b0;
        gap(4);
        check(d_en, 1'b1);
        // Read/write-select mode
        u_qrs_host_model.set_mode(1'b0, 1'b0);
        gap(4);
        check(d_en, 1'b0);
        check({ie, io}, 8'hf0);
        check(irq_w, 4'h0);
        @(posedge clk);
        pend <= 4'h0;
        csd_n <= 1'b1;
        gap(2);
        check(ie, 4'he);
        check(irq_w[0], 1'b1);
        // Ready pins and combined outputs
        @(posedge clk);
        room <= 4'h4;
        rxd  <= 4'h2;
        gap(2);
        check({tx_n, rx_n}, 8'hbd);
        check({ctx_n, crx_n}, 2'b00);
        @(posedge clk);
        room <= 4'h0;
        gap(2);
        check({ctx_n, crx_n}, 2'b10);
        @(posedge clk);
        rxd <= 4'h0;
        gap(2);
        check(crx_n, 1'b1);
        // Receive request, count pulse, rearm
        @(posedge clk);
        rxe <= 4'h1;
        rxd <= 4'h1;
        gap(3);
        check({rxr, rx_n}, 8'h1e);
        u_qrs_host_model.pulse_tc();
        gap(5);
        check(rxr, 4'h0);
        @(posedge clk);
        rxd <= 4'h0;
        gap(2);
        @(posedge clk);
        rxd <= 4'h1;
        gap(3);
        check(rxr, 4'h1);
        // Transmit request until above trigger
        @(posedge clk);
        txe  <= 4'h2;
        room <= 4'h2;
        gap(3);
        check({txr, tx_n}, 8'h2d);
        @(posedge clk);
        above <= 4'h2;
        gap(3);
        check({txr, tx_n}, 8'h0f);
        // Status byte with address-free read
        @(posedge clk);
        txe  <= 4'h0;
        rxe  <= 4'h0;
        room <= 4'h5;
        rxd  <= 4'h8;
        gap(3);
        u_qrs_host_model.read_status(v, ok);
        check(ok, 1'b1);
        check(v, {~4'h8, 4'h5});
        gap(5);
        check(d_oe, 1'b0);
        wrap_up();
    end
endmodule
`default_nettype wire

// ==== core/qrs_irq_ready.sv ====
// Purpose: Interrupt pins, ready pins, combined ready and pin-selected status byte
// Assumes: Core signals share clk; pin inputs pass a two-stage synchroniser
// Notes: Pull resistors modelled by the default level of unconnected pins
`timescale 1ns/100ps
`default_nettype none
module qrs_irq_ready
    import qrs_pkg::*;
#(
    parameter int unsigned NCH = QRS_CHANNELS
)(
    // Clock and reset
    input  wire logic           clk,
    input  wire logic           arst_n,
    // Bus pins
    input  wire logic           bus_mode_strobe,
    input  wire logic           chan_d_select_n,
    input  wire logic           irq_force_enable,
    input  wire logic           status_snapshot_sel_n,
    input  wire logic           terminal_count_pulse,
    // Core per-channel state
    input  wire logic [NCH-1:0] chan_irq_pending,
    input  wire logic [NCH-1:0] irq_output_enable_bit,
    input  wire logic [NCH-1:0] tx_xfer_enable,
    input  wire logic [NCH-1:0] rx_xfer_enable,
    input  wire logic [NCH-1:0] tx_has_room,
    input  wire logic [NCH-1:0] tx_above_trigger,
    input  wire logic [NCH-1:0] rx_has_data,
    // Channel D enable to core
    output logic                chan_d_enable,
    // Interrupt pins
    output logic [NCH-1:0]      chan_irq_out,
    output logic [NCH-1:0]      chan_irq_oe,
    // Ready pins
    output logic [NCH-1:0]      chan_tx_room_n,
    output logic [NCH-1:0]      chan_rx_avail_n,
    output logic                combined_tx_room_n,
    output logic                combined_rx_avail_n,
    // Transfer requests
    output logic [NCH-1:0]      tx_xfer_request,
    output logic [NCH-1:0]      rx_xfer_request,
    // Data bus
    output logic [7:0]          data_out,
    output logic                data_oe
);
    localparam logic [4:0] PIN_RESET = {QRS_PULLUP_LVL, QRS_PULLDOWN_LVL, QRS_PULLUP_LVL,
                                        QRS_PULLDOWN_LVL, QRS_PULLDOWN_LVL};

    logic           mode_strobe;
    logic           csd_n;
    logic           force_en;
    logic           snap_sel_n;
    logic           tc_sync;
    logic           tc_prev;
    logic           tc_pulse;
    logic [NCH-1:0] next_irq_out;
    logic [NCH-1:0] next_irq_oe;
    logic [NCH-1:0] next_tx_n;
    logic [NCH-1:0] next_rx_n;
    logic [7:0]     pin_ready_snapshot;

    // Pin synchronisers
    qrs_sync #(
        .WIDTH     (5),
        .RESET_VAL (PIN_RESET)
    ) u_pin_sync (
        .clk    (clk),
        .arst_n (arst_n),
        .din    ({status_snapshot_sel_n, irq_force_enable, chan_d_select_n,
                  bus_mode_strobe, terminal_count_pulse}),
        .dout   ({snap_sel_n, force_en, csd_n, mode_strobe, tc_sync})
    );

    // Terminal count edge
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            tc_prev <= 1'b0;
        else
            tc_prev <= tc_sync;
    end

    assign tc_pulse = tc_sync && !tc_prev;

    // Transfer request lines
    for (genvar i = 0; i < NCH; i++)
    begin : g_req
        qrs_xfer_req u_tx_req (
            .clk        (clk),
            .arst_n     (arst_n),
            .enable     (tx_xfer_enable[i]),
            .start_cond (tx_has_room[i] && !tx_above_trigger[i]),
            .stop_cond  (tx_above_trigger[i]),
            .tc_pulse   (tc_pulse),
            .request    (tx_xfer_request[i])
        );
        qrs_xfer_req u_rx_req (
            .clk        (clk),
            .arst_n     (arst_n),
            .enable     (rx_xfer_enable[i]),
            .start_cond (rx_has_data[i]),
            .stop_cond  (!rx_has_data[i]),
            .tc_pulse   (tc_pulse),
            .request    (rx_xfer_request[i])
        );
    end

    // Channel D select
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            chan_d_enable <= 1'b0;
        else
            chan_d_enable <= mode_strobe && !csd_n; // see RL2
    end

    // Interrupt pin drive
    always_comb
    begin
        next_irq_out = chan_irq_pending;
        next_irq_oe  = '0;
        if (mode_strobe)
        begin
            // see RL3 see RL4 see RL7 see RL8 see RL10
            next_irq_oe = force_en ? '1 : irq_output_enable_bit;
        end
        else
        begin
            // Shared open-drain request on channel A (see RL5)
            next_irq_out    = '0;
            next_irq_oe[0]  = |chan_irq_pending;
            // Idle pins held low (see RL6)
            next_irq_oe[NCH-1:1] = '1;
        end
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            chan_irq_out <= '0;
            chan_irq_oe  <= {NCH{QRS_IRQ_OE_RESET}};
        end
        else
        begin
            chan_irq_out <= next_irq_out;
            chan_irq_oe  <= next_irq_oe;
        end
    end

    // Ready pin selection
    always_comb
    begin
        for (int i = 0; i < NCH; i++)
        begin
            next_tx_n[i] = tx_xfer_enable[i] ? !tx_xfer_request[i] : !tx_has_room[i]; // see RL11 see RL12
            next_rx_n[i] = rx_xfer_enable[i] ? !rx_xfer_request[i] : !rx_has_data[i]; // see RL13 see RL14
        end
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            chan_tx_room_n      <= {NCH{QRS_READY_N_RESET}};
            chan_rx_avail_n     <= {NCH{QRS_READY_N_RESET}};
            combined_tx_room_n  <= QRS_READY_N_RESET;
            combined_rx_avail_n <= QRS_READY_N_RESET;
        end
        else
        begin
            chan_tx_room_n      <= next_tx_n;
            chan_rx_avail_n     <= next_rx_n;
            combined_tx_room_n  <= &next_tx_n; // see RL15 see RL17
            combined_rx_avail_n <= &next_rx_n; // see RL16 see RL17
        end
    end

    // Status byte from the pins as driven
    always_comb
    begin
        pin_ready_snapshot = QRS_DATA_RESET;
        pin_ready_snapshot[QRS_SNAP_TX_LSB +: NCH] = ~chan_tx_room_n; // see RL19
        pin_ready_snapshot[QRS_SNAP_RX_LSB +: NCH] = chan_rx_avail_n; // see RL20
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            data_out <= QRS_DATA_RESET;
            data_oe  <= 1'b0;
        end
        else
        begin
            data_out <= pin_ready_snapshot;
            data_oe  <= !snap_sel_n; // see RL18 see RL21
        end
    end

    // Checks
    sequence s_strobe_forced;
        arst_n && mode_strobe && force_en;
    endsequence

    sequence s_strobe_free;
        arst_n && mode_strobe && !force_en;
    endsequence

    sequence s_strobe_mode;
        arst_n && mode_strobe;
    endsequence

    sequence s_rw_mode;
        arst_n && !mode_strobe;
    endsequence

    sequence s_chan_d_picked;
        arst_n && mode_strobe && !csd_n;
    endsequence

    sequence s_snap_selected;
        arst_n && !snap_sel_n;
    endsequence

    sequence s_snap_released;
        arst_n && snap_sel_n;
    endsequence

    AST_FORCE_ALL: assert property (@(posedge clk) disable iff (!arst_n) // see RL7
        s_strobe_forced |=> (chan_irq_oe == '1))
        else $error("Forced interrupt outputs not all enabled");

    AST_ENABLE_BIT: assert property (@(posedge clk) disable iff (!arst_n) // see RL8
        s_strobe_free |=> (chan_irq_oe == $past(irq_output_enable_bit)))
        else $error("Interrupt drive does not follow enable bits");

    AST_CHAN_A_EN: assert property (@(posedge clk) disable iff (!arst_n) // see RL3
        s_strobe_free |=> (chan_irq_oe[0] == $past(irq_output_enable_bit[0])))
        else $error("Channel A interrupt drive does not follow its enable bit");

    AST_STROBE_LEVEL: assert property (@(posedge clk) disable iff (!arst_n) // see RL4
        s_strobe_mode |=> (chan_irq_out == $past(chan_irq_pending)))
        else $error("Interrupt outputs do not carry the pending levels");

    AST_CHAN_A_OD: assert property (@(posedge clk) disable iff (!arst_n) // see RL5
        s_rw_mode |=> !chan_irq_out[0] && (chan_irq_oe[0] == |$past(chan_irq_pending)))
        else $error("Shared interrupt not open drain");

    AST_IDLE_LOW: assert property (@(posedge clk) disable iff (!arst_n) // see RL6
        s_rw_mode |=> (chan_irq_out[NCH-1:1] == '0) && (chan_irq_oe[NCH-1:1] == '1))
        else $error("Unused interrupt pins not held low");

    AST_CHAN_D: assert property (@(posedge clk) disable iff (!arst_n) // see RL2
        s_rw_mode |=> !chan_d_enable)
        else $error("Channel D select not ignored");

    AST_CHAN_D_SEL: assert property (@(posedge clk) disable iff (!arst_n) // see RL2
        s_chan_d_picked |=> chan_d_enable)
        else $error("Channel D not enabled by its select");

    AST_TX_COMBINED: assert property (@(posedge clk) disable iff (!arst_n) // see RL15
        combined_tx_room_n == &chan_tx_room_n)
        else $error("Combined transmit ready mismatch");

    AST_RX_COMBINED: assert property (@(posedge clk) disable iff (!arst_n) // see RL16
        combined_rx_avail_n == &chan_rx_avail_n)
        else $error("Combined receive ready mismatch");

    AST_TX_ANY_LOW: assert property (@(posedge clk) disable iff (!arst_n) // see RL17
        (chan_tx_room_n != '1) |-> !combined_tx_room_n)
        else $error("Combined transmit ready not low with a channel low");

    AST_RX_ANY_LOW: assert property (@(posedge clk) disable iff (!arst_n) // see RL17
        (chan_rx_avail_n != '1) |-> !combined_rx_avail_n)
        else $error("Combined receive ready not low with a channel low");

    AST_TX_PIN_FIFO: assert property (@(posedge clk) disable iff (!arst_n) // see RL11
        arst_n |=> (((chan_tx_room_n ^ ~$past(tx_has_room))
                     & ~$past(tx_xfer_enable)) == '0))
        else $error("Transmit ready pin not following room state");

    AST_TX_PIN_REQ: assert property (@(posedge clk) disable iff (!arst_n) // see RL12
        arst_n |=> (((chan_tx_room_n ^ ~$past(tx_xfer_request))
                     & $past(tx_xfer_enable)) == '0))
        else $error("Transmit ready pin not carrying request");

    AST_RX_PIN_FIFO: assert property (@(posedge clk) disable iff (!arst_n) // see RL13
        arst_n |=> (((chan_rx_avail_n ^ ~$past(rx_has_data))
                     & ~$past(rx_xfer_enable)) == '0))
        else $error("Receive ready pin not following data state");

    AST_RX_PIN_REQ: assert property (@(posedge clk) disable iff (!arst_n) // see RL14
        arst_n |=> (((chan_rx_avail_n ^ ~$past(rx_xfer_request))
                     & $past(rx_xfer_enable)) == '0))
        else $error("Receive ready pin not carrying request");

    AST_TC_CLEARS: assert property (@(posedge clk) disable iff (!arst_n) // see RL22
        arst_n && tc_pulse |=> (tx_xfer_request == '0) && (rx_xfer_request == '0))
        else $error("Terminal count did not clear the requests");

    AST_SNAPSHOT: assert property (@(posedge clk) disable iff (!arst_n) // see RL18
        s_snap_selected |=> data_oe
            && (data_out == {$past(chan_rx_avail_n), ~$past(chan_tx_room_n)}))
        else $error("Status byte wrong while selected");

    AST_SNAP_TX: assert property (@(posedge clk) disable iff (!arst_n) // see RL19
        s_snap_selected |=> (data_out[QRS_SNAP_TX_LSB +: NCH] == ~$past(chan_tx_room_n)))
        else $error("Status byte transmit bits not inverted pins");

    AST_SNAP_RX: assert property (@(posedge clk) disable iff (!arst_n) // see RL20
        s_snap_selected |=> (data_out[QRS_SNAP_RX_LSB +: NCH] == $past(chan_rx_avail_n)))
        else $error("Status byte receive bits not pin levels");

    AST_SNAP_RELEASE: assert property (@(posedge clk) disable iff (!arst_n) // see RL21
        s_snap_released |=> !data_oe)
        else $error("Data bus driven while status select inactive");
endmodule
`default_nettype wire

// ==== core/qrs_pkg.sv ====
// Purpose: Shared constants for the quad channel interrupt and ready block
// Assumes: Four channels, one 40 MHz clock, asynchronous active-low reset
// Notes: Overview of operation
// Overview of operation
// RL1 - Host ties bus-style pin high for strobe mode, low for read/write-select mode.
// RL2 - Strobe mode: low channel D select enables channel D; otherwise ignored.
// RL3 - Strobe mode: channel A interrupt driven when enable bit is 1, else floats.
// RL4 - Strobe mode: channels B to D interrupts follow the same enable rule.
// RL5 - Read/write-select mode: channel A pin is shared open-drain active-low request.
// RL6 - Read/write-select mode: channel B to D interrupt pins held at zero.
// RL7 - Strobe mode: high force input keeps all four interrupt outputs enabled.
// RL8 - Strobe mode: force input low lets each enable bit decide drive.
// RL9 - Host holds force input low in read/write-select mode.
// RL10 - Force input is active high, pulled down when unconnected.
// RL11 - Each channel drives active-low transmit-ready from its transmit buffer state.
// RL12 - With transfer mode enabled, transmit-ready pin carries the transmit request.
// RL13 - Each channel drives active-low receive-ready from its receive buffer state.
// RL14 - With transfer mode enabled, receive-ready pin carries the receive request.
// RL15 - Combined transmit-ready is wire-OR of the four channel states.
// RL16 - Combined receive-ready is wire-OR of the four channel states.
// RL17 - Combined output low whenever any channel ready output is low.
// RL18 - Status select low places ready byte on data bus, address ignored.
// RL19 - Ready byte bits 3:0 are inverted channel A to D transmit-ready pins.
// RL20 - Ready byte bits 7:4 are uninverted channel A to D receive-ready pins.
// RL21 - Status select is active low, pulled up when unconnected.
// RL22 - Transmit request held until terminal count or buffer above trigger.
// RL23 - Receive request held until terminal count or receive buffer empty.
package qrs_pkg;
    localparam int unsigned QRS_CHANNELS      = 4;
    localparam int unsigned QRS_SYNC_STAGES   = 2;
    localparam logic        QRS_IRQ_OE_RESET  = 1'b0;
    localparam logic        QRS_READY_N_RESET = 1'b1;
    localparam logic        QRS_REQ_RESET     = 1'b0;
    localparam logic        QRS_ARMED_RESET   = 1'b1;
    localparam logic [7:0]  QRS_DATA_RESET    = 8'h00;
    localparam int unsigned QRS_SNAP_TX_LSB   = 0;
    localparam int unsigned QRS_SNAP_RX_LSB   = 4;
    localparam int unsigned QRS_XFER_TX_BIT   = 2;
    localparam int unsigned QRS_XFER_RX_BIT   = 3;
    localparam int unsigned QRS_IRQ_EN_BIT    = 3;
    localparam logic        QRS_PULLDOWN_LVL  = 1'b0;
    localparam logic        QRS_PULLUP_LVL    = 1'b1;
endpackage

// ==== core/qrs_sync.sv ====
// Purpose: Two flip-flop synchroniser for pin inputs
// Assumes: Inputs are asynchronous to clk
// Notes: First stage is read only by the second
`timescale 1ns/100ps
`default_nettype none
module qrs_sync
    import qrs_pkg::*;
#(
    parameter int unsigned WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
)(
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             arst_n,
    // Data
    input  wire logic [WIDTH-1:0] din,
    output logic      [WIDTH-1:0] dout
);
    logic [WIDTH-1:0] meta;

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            meta <= RESET_VAL;
            dout <= RESET_VAL;
        end
        else
        begin
            meta <= din;
            dout <= meta;
        end
    end
endmodule
`default_nettype wire

// ==== core/qrs_xfer_req.sv ====
// Purpose: One transfer request line with start, stop and terminal count
// Assumes: All inputs on clk; tc_pulse is a one-cycle pulse
// Notes: After terminal count, rearms once the stop condition is seen or enable is low
`timescale 1ns/100ps
`default_nettype none
module qrs_xfer_req
    import qrs_pkg::*;
(
    // Clock and reset
    input  wire logic clk,
    input  wire logic arst_n,
    // Control
    input  wire logic enable,
    input  wire logic start_cond,
    input  wire logic stop_cond,
    input  wire logic tc_pulse,
    // Request
    output logic      request
);
    logic armed;

    // Held high until terminal count or stop condition (see RL22) (see RL23)
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            request <= QRS_REQ_RESET;
            armed   <= QRS_ARMED_RESET;
        end
        else if (!enable || stop_cond)
        begin
            request <= 1'b0;
            armed   <= 1'b1;
        end
        else if (tc_pulse)
        begin
            request <= 1'b0;
            armed   <= 1'b0;
        end
        else if (start_cond && armed)
        begin
            request <= 1'b1;
        end
    end

    AST_REQ_DROP: assert property (@(posedge clk) disable iff (!arst_n) // see RL22
        (tc_pulse || stop_cond || !enable) |=> !request)
        else $error("Request not dropped after terminal count or stop");

    AST_REQ_HOLD: assert property (@(posedge clk) disable iff (!arst_n) // see RL23
        (request && enable && !stop_cond && !tc_pulse) |=> request)
        else $error("Request dropped without terminal count or stop");
endmodule
`default_nettype wire
